// *** rtl/pim_defs.svh ***
// Constants for the parallel integer multiplier block
`ifndef PIM_DEFS_SVH
`define PIM_DEFS_SVH

// ==========================================================================
// Fixed bus widths (largest legal configuration)
`define PIM_OP_W 32
`define PIM_PROD_W 64
`define PIM_SEL_W 3

// ==========================================================================
// Configuration limits
`define PIM_MIN_COUNT 2
`define PIM_MIN_WIDTH 3
`define PIM_NARROW_MAX_W 4
`define PIM_NARROW_MAX_N 8
`define PIM_MID_MAX_W 8
`define PIM_MID_MAX_N 4
`define PIM_WIDE_W 16
`define PIM_WIDE_MAX_N 2

// ==========================================================================
// Register byte addresses
`define PIM_ADDR_W 12
`define PIM_REG_CFG 12'h000
`define PIM_REG_SEL 12'h004
`define PIM_REG_PROD 12'h008

// ==========================================================================
// Configuration word field positions and reset value
`define PIM_CFG_WIDTH_LSB 8
`define PIM_CFG_UNS_A_BIT 16
`define PIM_CFG_UNS_B_BIT 17
`define PIM_CFG_INREG_BIT 18
`define PIM_CFG_PIPE_BIT 19
`define PIM_STATE_RST '0

`endif

// *** rtl/pim_pkg.sv ***
// Types shared by the parallel integer multiplier block
`include "pim_defs.svh"

package pim_pkg;

    // ======================================================================
    // Operand pair carrier
    typedef struct packed {
        logic [`PIM_OP_W-1:0] a;
        logic [`PIM_OP_W-1:0] b;
    } pim_ops_t;

    // ======================================================================
    // Whole state of the top module
    typedef struct packed {
        logic [`PIM_OP_W-1:0] a_q;
        logic [`PIM_OP_W-1:0] b_q;
        logic [`PIM_PROD_W-1:0] prod_q;
        logic [`PIM_SEL_W-1:0] sel;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } pim_state_t;

endpackage : pim_pkg

// *** rtl/pim_top.sv ***
// Parallel integer multiplier array with an APB status and readback port
//
// N_MULT lanes of WIDTH x WIDTH multipliers share the packed operand buses.
// Latency is IN_REG cycles plus one when PIPE_STAGES is 1; with neither, dout is combinational.
// The APB port only reports the build and reads back one product; it never
// steers the datapath, so the datapath may run with the bus left idle.
//
// The placing of the registers and register access over APB are this design's own decisions.
`timescale 1ns/1ns
`include "pim_defs.svh"

module pim_top #(
    parameter int N_MULT = 4,
    parameter int WIDTH = 8,
    parameter bit UNSIGNED_A = 1'b0,
    parameter bit UNSIGNED_B = 1'b0,
    parameter bit IN_REG = 1'b0,
    parameter bit HIDE_IN_CTRL = 1'b0,
    parameter int PIPE_STAGES = 0,
    parameter bit HIDE_PIPE_CTRL = 1'b0
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic [`PIM_ADDR_W-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Packed operands
    input wire logic [N_MULT*WIDTH-1:0] din_a,
    input wire logic [N_MULT*WIDTH-1:0] din_b,
    // Input register controls
    input wire logic in_a_ce,
    input wire logic in_b_ce,
    input wire logic in_reg_rstn,
    // Pipeline register controls
    input wire logic pipe_ce,
    input wire logic pipe_rstn,
    // Concatenated products
    output logic [2*N_MULT*WIDTH-1:0] dout
);

    // ======================================================================
    // Derived sizes and configuration check
    // Illegal count and width pairs are flagged by assertion, not blocked, so a
    // wrong build still elaborates and the check names the problem
    localparam int PW = 2 * WIDTH;
    localparam int OUTW = N_MULT * PW;
    localparam bit PIPE = (PIPE_STAGES == 1);
    localparam bit LEGAL = (N_MULT >= `PIM_MIN_COUNT) && (
        (WIDTH >= `PIM_MIN_WIDTH && WIDTH <= `PIM_NARROW_MAX_W
            && N_MULT <= `PIM_NARROW_MAX_N) ||
        (WIDTH > `PIM_NARROW_MAX_W && WIDTH <= `PIM_MID_MAX_W
            && N_MULT <= `PIM_MID_MAX_N) ||
        (WIDTH == `PIM_WIDE_W && N_MULT <= `PIM_WIDE_MAX_N));

    pim_pkg::pim_state_t st;
    pim_pkg::pim_state_t next_st;
    pim_pkg::pim_ops_t ops_in;
    pim_pkg::pim_ops_t ops_mul;
    logic [OUTW-1:0] prod_lanes;
    logic [`PIM_PROD_W-1:0] prod_comb;
    logic [`PIM_PROD_W-1:0] dout_wide;
    logic [`PIM_PROD_W-1:0] sel_shift;
    logic [31:0] cfg_word;
    logic [31:0] sel_prod;
    logic a_ce;
    logic b_ce;
    logic in_rstn;
    logic p_ce;
    logic p_rstn;

    // ======================================================================
    // Control pins; hidden controls read as constant one
    // Hidden controls keep their ports so one netlist fits every option; the
    // pin value is then simply ignored, whatever the user logic drives
    assign a_ce = HIDE_IN_CTRL ? 1'b1 : in_a_ce;
    assign b_ce = HIDE_IN_CTRL ? 1'b1 : in_b_ce;
    assign in_rstn = HIDE_IN_CTRL ? 1'b1 : in_reg_rstn;
    assign p_ce = HIDE_PIPE_CTRL ? 1'b1 : pipe_ce;
    assign p_rstn = HIDE_PIPE_CTRL ? 1'b1 : pipe_rstn;

    // ======================================================================
    // Operand staging: raw pins or the input register
    // Narrow builds leave the top of the 32-bit carriers at zero
    assign ops_in.a = `PIM_OP_W'(din_a);
    assign ops_in.b = `PIM_OP_W'(din_b);
    assign ops_mul.a = IN_REG ? st.a_q : ops_in.a;
    assign ops_mul.b = IN_REG ? st.b_q : ops_in.b;

    // ======================================================================
    // Multiplier array; one extra sign bit makes signed and unsigned share a path
    // An unsigned operand gets a zero in the extra bit, a signed one a copy of
    // its top bit, so one signed multiply serves all four mixes. Only the low
    // 2*WIDTH bits are kept: the bits above them carry nothing but sign
    for (genvar i = 0; i < N_MULT; i++) begin : g_mult
        logic signed [WIDTH:0] ax;
        logic signed [WIDTH:0] bx;
        logic signed [2*WIDTH+1:0] px;
        assign ax = {(UNSIGNED_A ? 1'b0 : ops_mul.a[i*WIDTH+WIDTH-1]),
                     ops_mul.a[i*WIDTH +: WIDTH]};
        assign bx = {(UNSIGNED_B ? 1'b0 : ops_mul.b[i*WIDTH+WIDTH-1]),
                     ops_mul.b[i*WIDTH +: WIDTH]};
        assign px = ax * bx;
        assign prod_lanes[i*PW +: PW] = px[PW-1:0];
    end

    assign prod_comb = `PIM_PROD_W'(prod_lanes);
    // Zero-stage builds without IN_REG are combinational from pins to dout by design
    assign dout_wide = PIPE ? st.prod_q : prod_comb;
    assign dout = dout_wide[OUTW-1:0];

    // ======================================================================
    // Readback words
    // PROD shows the selected lane after all stages; an index past the last
    // lane shifts in zeros, so it reads zero rather than a stale lane
    assign cfg_word = 32'(N_MULT) | (32'(WIDTH) << `PIM_CFG_WIDTH_LSB)
        | (32'(UNSIGNED_A) << `PIM_CFG_UNS_A_BIT)
        | (32'(UNSIGNED_B) << `PIM_CFG_UNS_B_BIT)
        | (32'(IN_REG) << `PIM_CFG_INREG_BIT)
        | (32'(PIPE) << `PIM_CFG_PIPE_BIT);
    assign sel_shift = dout_wide >> (int'(st.sel) * PW);
    assign sel_prod = 32'(sel_shift[PW-1:0]);

    // ======================================================================
    // Next-state logic
    always_comb begin
        next_st = st;
        // Input register: reset beats enable, low enable holds
        if (!in_rstn) begin
            next_st.a_q = `PIM_STATE_RST;
            next_st.b_q = `PIM_STATE_RST;
        end else begin
            if (a_ce) begin
                next_st.a_q = ops_in.a;
            end
            if (b_ce) begin
                next_st.b_q = ops_in.b;
            end
        end
        // Pipeline stage: reset beats enable here too
        if (!p_rstn) begin
            next_st.prod_q = `PIM_STATE_RST;
        end else if (p_ce) begin
            next_st.prod_q = prod_comb;
        end
        // APB: decode in setup so pready and data come from flops
        // Trade-off: PROD is captured at the setup edge, one cycle before the
        // access edge, in exchange for zero wait states and registered outputs
        next_st.pready = 1'b0;
        next_st.pslverr = 1'b0;
        if (psel && !penable) begin
            next_st.pready = 1'b1;
            case (paddr)
                `PIM_REG_CFG: next_st.prdata = cfg_word;
                `PIM_REG_SEL: next_st.prdata = 32'(st.sel);
                `PIM_REG_PROD: next_st.prdata = sel_prod;
                default: begin
                    next_st.prdata = `PIM_STATE_RST;
                    next_st.pslverr = 1'b1;
                end
            endcase
        end
        // A write lands only on the completing access edge
        if (psel && penable && st.pready && pwrite && paddr == `PIM_REG_SEL) begin
            next_st.sel = pwdata[`PIM_SEL_W-1:0];
        end
    end

    // ======================================================================
    // State register
    // presetn clears the datapath registers as well as the bus side
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st <= `PIM_STATE_RST;
        end else begin
            st <= next_st;
        end
    end

    assign prdata = st.prdata;
    assign pready = st.pready;
    assign pslverr = st.pslverr;

    // ======================================================================
    // Assertions and coverage
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    count_limit_a: assert property (LEGAL)
        else $error("multiplier count not allowed for this width");
    width_range_a: assert property (
        (WIDTH >= `PIM_MIN_WIDTH && WIDTH <= `PIM_MID_MAX_W) || WIDTH == `PIM_WIDE_W)
        else $error("operand width outside legal set");
    hide_input_a: assert property (
        HIDE_IN_CTRL |-> (a_ce && b_ce && in_rstn))
        else $error("hidden input controls not held high");
    hide_pipe_a: assert property (
        HIDE_PIPE_CTRL |-> (p_ce && p_rstn))
        else $error("hidden pipeline controls not held high");
    in_load_a: assert property (
        (IN_REG && in_rstn && a_ce && b_ce) |=> (ops_mul == $past(ops_in)))
        else $error("input register did not load operands");
    in_clear_a: assert property (
        (IN_REG && !in_rstn) |=> (ops_mul.a == '0 && ops_mul.b == '0))
        else $error("input register not cleared by its reset");
    in_hold_a: assert property (
        (in_rstn && !a_ce) |=> $stable(st.a_q))
        else $error("operand A register changed while disabled");
    pipe_load_a: assert property (
        (PIPE && p_rstn && p_ce) |=> (dout_wide == $past(prod_comb)))
        else $error("pipeline stage did not capture products");
    pipe_clear_a: assert property (
        (PIPE && !p_rstn) ##1 (p_rstn && !p_ce) |-> (dout == '0) ##1 $stable(dout))
        else $error("pipeline stage not cleared or not held");
    sign_lane_a: assert property (
        (!UNSIGNED_A && !UNSIGNED_B && ops_mul.a[WIDTH-1:0] == '1
         && ops_mul.b[WIDTH-1:0] == WIDTH'(1)) |-> (prod_comb[PW-1:0] == '1))
        else $error("signed product of minus one and one is wrong");
    apb_ready_a: assert property (
        (psel && !penable) |=> (pready ##1 !pready))
        else $error("APB answer is not a single-cycle ready");
    // No answer may appear without a request behind it
    apb_idle_a: assert property (
        !psel |=> !pready)
        else $error("APB ready without a request");
    // An error answer always comes with ready and empty read data
    apb_error_a: assert property (
        pslverr |-> (pready && prdata == '0))
        else $error("APB error without ready or with data");
    // SEL takes the write data only on the completing access edge
    sel_write_a: assert property (
        (psel && penable && pready && pwrite && paddr == `PIM_REG_SEL)
        |=> (st.sel == $past(pwdata[`PIM_SEL_W-1:0])))
        else $error("SEL write did not land");
    // Configuration readback reflects the build options
    cfg_read_a: assert property (
        (psel && !penable && paddr == `PIM_REG_CFG) |=> (prdata == cfg_word))
        else $error("configuration readback is wrong");

    // ======================================================================
    // Count range, register hold, bypass and unsigned lane checks
    count_range_a: assert property (
        N_MULT >= `PIM_MIN_COUNT && N_MULT <= `PIM_NARROW_MAX_N)
        else $error("multiplier count outside two to eight");
    // A low enable freezes its register even while the other one loads
    in_hold_b_a: assert property (
        (in_rstn && !b_ce) |=> $stable(st.b_q))
        else $error("operand B register changed while disabled");
    pipe_hold_a: assert property (
        (PIPE && p_rstn && !p_ce) |=> $stable(st.prod_q))
        else $error("pipeline stage changed while disabled");
    // Without the optional stages nothing may sit between pins and products
    in_bypass_a: assert property (
        !IN_REG |-> (ops_mul == ops_in))
        else $error("operands delayed without input register");
    pipe_bypass_a: assert property (
        !PIPE |-> (dout_wide == prod_comb))
        else $error("products delayed without pipeline stage");
    // Unsigned A: all ones times one must come out positive, not minus one
    unsigned_lane_a: assert property (
        (UNSIGNED_A && !UNSIGNED_B && ops_mul.a[WIDTH-1:0] == '1
         && ops_mul.b[WIDTH-1:0] == WIDTH'(1))
        |-> (prod_comb[PW-1:0] == PW'({WIDTH{1'b1}})))
        else $error("unsigned A product of all ones and one is wrong");

    in_stall_c: cover property (IN_REG && !a_ce ##1 !a_ce ##1 a_ce);
    pipe_reset_c: cover property (PIPE && !p_rstn ##1 p_rstn && p_ce);
    prod_read_c: cover property (psel && penable && pready && !pwrite
        && paddr == `PIM_REG_PROD);
    sel_write_c: cover property (psel && penable && pready && pwrite
        && paddr == `PIM_REG_SEL);
    unsigned_top_c: cover property (UNSIGNED_A && ops_mul.a[WIDTH-1]);

endmodule : pim_top

// *** tb/pim_user_model.sv ***
// Model of the user logic that feeds operands and register controls
`timescale 1ns/1ns

module pim_user_model #(
    parameter int N = 4,
    parameter int W = 8
) (
    // Operands and controls
    output pim_pkg::pim_ops_t ops,
    output logic [4:0] ctl
);
    // ======================================================================
    // Drive tasks
    // Called right after a rising edge; values land by non-blocking update
    initial begin
        ops = '0;
        ctl = 5'h1F;
    end

    // Lane i of each operand sits at bits i*W upward
    task automatic put(input logic [W-1:0] a[N], input logic [W-1:0] b[N]);
        for (int i = 0; i < N; i++) begin
            ops.a[i*W +: W] <= a[i];
            ops.b[i*W +: W] <= b[i];
        end
    endtask : put

    // Order: a_ce, b_ce, in_reg_rstn, pipe_ce, pipe_rstn
    task automatic set_ctl(input logic [4:0] c);
        ctl <= c;
    endtask : set_ctl
endmodule : pim_user_model

// *** tb/pim_bench.sv ***
// Self-checking bench for the parallel integer multiplier array
`timescale 1ns/1ns
`include "pim_defs.svh"

module pim_bench;
    // ======================================================================
    // Signals
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic [`PIM_ADDR_W-1:0] paddr = '0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] pwdata = '0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    pim_pkg::pim_ops_t ops;
    logic [4:0] ctl;
    logic [63:0] dout;
    logic [63:0] dout2;
    logic [63:0] dout3;
    logic [31:0] rd;
    logic er;
    logic [7:0] xa[4];
    logic [7:0] xb[4];
    logic [63:0] ey;
    logic [63:0] ez;
    int fail_count = 0;
    int n_compared = 0;

    // Clock at 100 MHz
    always #5 pclk = ~pclk;

    pim_user_model #(.N(4), .W(8)) um (.ops(ops), .ctl(ctl));

    // Both register stages on, so latency is two cycles
    pim_top #(.IN_REG(1'b1), .PIPE_STAGES(1)) dut (
        .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .din_a(ops.a), .din_b(ops.b), .in_a_ce(ctl[4]),
        .in_b_ce(ctl[3]), .in_reg_rstn(ctl[2]), .pipe_ce(ctl[1]), .pipe_rstn(ctl[0]),
        .dout(dout)
    );

    // Two 16-bit lanes, A unsigned, both stages on; hidden controls tied low
    pim_top #(.N_MULT(2), .WIDTH(16), .UNSIGNED_A(1'b1), .IN_REG(1'b1),
              .HIDE_IN_CTRL(1'b1), .PIPE_STAGES(1), .HIDE_PIPE_CTRL(1'b1)) dut2 (
        .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(1'b0), .penable(1'b0),
        .pwrite(1'b0), .pwdata(pwdata), .prdata(), .pready(), .pslverr(),
        .din_a(ops.a), .din_b(ops.b), .in_a_ce(1'b0), .in_b_ce(1'b0),
        .in_reg_rstn(1'b0), .pipe_ce(1'b0), .pipe_rstn(1'b0), .dout(dout2)
    );

    // Default build: four signed 8-bit lanes, no registers, controls ignored
    pim_top dut3 (
        .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(1'b0), .penable(1'b0),
        .pwrite(1'b0), .pwdata(pwdata), .prdata(), .pready(), .pslverr(),
        .din_a(ops.a), .din_b(ops.b), .in_a_ce(1'b0), .in_b_ce(1'b0),
        .in_reg_rstn(1'b0), .pipe_ce(1'b0), .pipe_rstn(1'b0), .dout(dout3)
    );

    // ======================================================================
    // Helpers
    function automatic logic [15:0] mul(input logic signed [7:0] a,
                                        input logic signed [7:0] b);
        mul = a * b;
    endfunction : mul

    function automatic logic [63:0] prods(input logic [7:0] a[4], input logic [7:0] b[4]);
        for (int i = 0; i < 4; i++) prods[i*16 +: 16] = mul(a[i], b[i]);
    endfunction : prods

    // Two 16-bit lanes built from byte pairs: A unsigned, B signed
    function automatic logic [63:0] p16(input logic [7:0] a[4], input logic [7:0] b[4]);
        longint pv;
        for (int j = 0; j < 2; j++) begin
            pv = longint'({a[2*j+1], a[2*j]}) * longint'($signed({b[2*j+1], b[2*j]}));
            p16[j*32 +: 32] = pv[31:0];
        end
    endfunction : p16

    task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // Request held until pready is seen high at a rising edge
    task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
        @(posedge pclk);
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        psel <= 1'b1;
        @(posedge pclk);
        penable <= 1'b1;
        // Only the watchdog ends a wait that never sees pready
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // Apply xa, xb and controls, then judge dout one and two edges later
    task automatic feed(input logic [4:0] c, input logic [63:0] e1, input logic [63:0] e2);
        logic [63:0] e16;
        e16 = p16(xa, xb);
        @(posedge pclk);
        um.put(xa, xb);
        um.set_ctl(c);
        @(posedge pclk);
        #1;
        chk("dout one edge", e1, dout);
        chk("default dout", prods(xa, xb), dout3);
        @(posedge pclk);
        #1;
        chk("dout two edges", e2, dout);
        chk("hidden dout", e16, dout2);
    endtask : feed

    // ======================================================================
    // Scenarios
    task automatic t_reset();
        chk("dout after reset", 64'h0, dout);
        apb(`PIM_REG_CFG, 1'b0, 32'h0);
        chk("cfg", 64'h000C0804, {32'h0, rd});
    endtask : t_reset

    // Signed corners, lane layout, exactly two cycles of latency
    task automatic t_latency();
        xa = '{8'hFF, 8'hFF, 8'hFD, 8'h80};
        xb = '{8'h01, 8'h00, 8'h04, 8'h80};
        feed(5'h1F, 64'h0, prods(xa, xb));
    endtask : t_latency

    // Pipeline enable low holds; A enable low keeps the old A operand
    task automatic t_enables();
        ez = prods(xa, xb);
        xa = '{8'h01, 8'h02, 8'h03, 8'h04};
        xb = '{8'hFF, 8'hFE, 8'hFD, 8'hFC};
        ey = prods(xa, xb);
        feed(5'h1D, ez, ez);
        xb = '{8'h7F, 8'h7F, 8'hEE, 8'h3C};
        ez = prods(xa, xb);
        xa = '{8'h7F, 8'h80, 8'h11, 8'hC3};
        feed(5'h0F, ey, ez);
    endtask : t_enables

    // Synchronous clears win over low enables
    task automatic t_clears();
        feed(5'h03, ez, 64'h0);
        ez = prods(xa, xb);
        feed(5'h1F, 64'h0, ez);
        feed(5'h1C, 64'h0, 64'h0);
        feed(5'h15, 64'h0, 64'h0);
        feed(5'h1F, ez, ez);
    endtask : t_clears

    // Readback of one lane, then an unmapped address
    task automatic t_regs();
        apb(`PIM_REG_SEL, 1'b1, 32'h2);
        apb(`PIM_REG_PROD, 1'b0, 32'h0);
        chk("prod lane 2", {48'h0, ez[47:32]}, {32'h0, rd});
        apb(12'h00C, 1'b0, 32'h0);
        chk("unmapped", 64'h1, {63'h0, er});
    endtask : t_regs

    task automatic report_and_stop();
        $display("compared %0d failed %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : report_and_stop

    // Main sequence after six cycles of reset
    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_latency();
        t_enables();
        t_clears();
        t_regs();
        report_and_stop();
    end

    // Watchdog, far beyond the few dozen cycles the run needs
    initial begin
        #100000;
        fail_count++;
        report_and_stop();
    end
endmodule : pim_bench
